// ===== cycle_timer.sv
`timescale 1ns/1ns
// Up counter that fires a one-cycle pulse after load+1 units
module cycle_timer #(
    parameter int UNIT_CYC = 32000,
    parameter int LOADW    = 7
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [LOADW-1:0] load,
    output logic                  expired
);
    if (UNIT_CYC < 2) $error("UNIT_CYC too small");

    logic [31:0]      unit_q;   // Cycles within one unit
    logic [LOADW-1:0] units_q;  // Whole units already run

    // ------------------------------------------------------------
    // Counting; load read live so a fresh window applies at once
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        expired <= 1'b0;
        if (!rst_n || !run || restart)
        begin
            unit_q  <= 32'h0000_0000;
            units_q <= '0;
        end
        else if (unit_q == 32'(UNIT_CYC - 1))
        begin
            unit_q <= 32'h0000_0000;
            // Greater-or-equal copes with a window shrunk mid-count
            if (units_q >= load)
            begin
                expired <= 1'b1;
                units_q <= '0;
            end
            else
                units_q <= units_q + 1'b1;
        end
        else
            unit_q <= unit_q + 32'h0000_0001;
    end
endmodule

// ===== led_ctrl_regs.sv
`timescale 1ns/1ns
// Control registers 0x05..0x0d of the matrix driver
module led_ctrl_regs #(
    parameter int WDOG_UNIT = led_regs_pkg::WDOG_UNIT_CYC,
    parameter int TF_SCALE  = 125000  // Cycles per ms
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,        // Register write strobe
    input  wire logic       rd_en,        // Register read strobe
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       bus_activity, // Any bus edge seen
    input  wire logic       bus_stuck,    // SDA or SCL held low
    input  wire logic       test_done,    // Fault scan finished
    input  wire logic [5:0] test_result,  // Shorts C..A, opens C..A
    input  wire logic       supply_ok,    // Supply high enough
    output logic [7:0]      rdata,
    output logic [7:0]      cur_a,
    output logic [7:0]      cur_b,
    output logic [7:0]      cur_c,
    output logic            pump_on,
    output logic            test_start,
    output logic            test_all_leds,
    output logic            test_no_light,
    output logic            shutdown,
    output logic            bus_if_reset
);
    if (TF_SCALE < 1) $error("TF_SCALE must be positive");

    typedef enum logic [2:0] {
        PS_OFF  = 3'b001,
        PS_RUN  = 3'b010,
        PS_TRY  = 3'b100
    } pump_state_t;

    logic [7:0]  pump_q;     // Pump configuration
    logic [7:0]  test_q;     // Fault test control
    logic [7:0]  pdown_q;    // Power-down control
    logic [7:0]  wdog_q;     // Watchdog configuration
    logic [7:0]  fstat_q;    // Fault status
    logic [1:0]  gstat_q;    // Monitor and power-on flags
    logic        wd_fire;    // Watchdog expiry pulse
    pump_state_t ps_q;       // Pump control state
    logic [31:0] tf_cnt_q;   // Reduce-supply window counter
    logic [31:0] tf_len;     // Window length in cycles

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cur_a   <= led_regs_pkg::CUR_RST;
            cur_b   <= led_regs_pkg::CUR_RST;
            cur_c   <= led_regs_pkg::CUR_RST;
            pump_q  <= led_regs_pkg::PUMP_RST;
            test_q  <= led_regs_pkg::TEST_RST;
            pdown_q <= led_regs_pkg::PDOWN_RST;
            wdog_q  <= led_regs_pkg::WDOG_RST;
        end
        else if (wr_en)
        begin
            // Reserved bits masked off
            unique case (addr)
                led_regs_pkg::CUR_A_ADDR: cur_a <= wdata;
                led_regs_pkg::CUR_B_ADDR: cur_b <= wdata;
                led_regs_pkg::CUR_C_ADDR: cur_c <= wdata;
                led_regs_pkg::PUMP_ADDR:
                    pump_q <= wdata & led_regs_pkg::PUMP_MASK;
                led_regs_pkg::TEST_ADDR:
                    test_q <= wdata & led_regs_pkg::TEST_MASK;
                led_regs_pkg::PDOWN_ADDR:
                    pdown_q <= wdata & led_regs_pkg::PDOWN_MASK;
                led_regs_pkg::WDOG_ADDR:
                    wdog_q <= wdata & led_regs_pkg::WDOG_MASK;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Fault test launch and status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            test_start    <= 1'b0;
            test_all_leds <= 1'b0;
            test_no_light <= 1'b0;
            fstat_q       <= 8'h00;
        end
        else
        begin
            // Write of zero in bit 0 launches a scan unless one is busy
            test_start <= wr_en && addr == led_regs_pkg::TEST_ADDR
                          && !wdata[led_regs_pkg::TEST_RUN_BIT]
                          && !fstat_q[led_regs_pkg::FSTAT_BUSY];
            // Full matrix: all LEDs present, none lit
            test_all_leds <= test_q[led_regs_pkg::TEST_FULL_BIT];
            test_no_light <= test_q[led_regs_pkg::TEST_FULL_BIT];
            if (test_done)
                fstat_q <= {2'b00, test_result};
            else if (test_start)
                fstat_q[led_regs_pkg::FSTAT_BUSY] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Shutdown output
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            shutdown <= 1'b1;
        else
            shutdown <= !pdown_q[led_regs_pkg::PDOWN_BIT];
    end

    // ------------------------------------------------------------
    // Bus watchdog
    // ------------------------------------------------------------
    cycle_timer #(
        .UNIT_CYC (WDOG_UNIT),
        .LOADW    (7)
    ) u_wdog (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (wdog_q[led_regs_pkg::WDOG_EN_BIT] && bus_stuck),
        .restart  (bus_activity),
        .load     (wdog_q[7:led_regs_pkg::WDOG_TO_LO]),
        .expired  (wd_fire)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            bus_if_reset <= 1'b0;
        else
            bus_if_reset <= wd_fire;
    end

    // ------------------------------------------------------------
    // General status flags, cleared by read; set wins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            gstat_q <= 2'b01;  // Power-on flag set at start-up
        else
        begin
            if (rd_en && addr == led_regs_pkg::GSTAT_ADDR)
                gstat_q <= 2'b00;
            if (wd_fire)
                gstat_q[1] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Charge pump control with reduce-supply attempt
    // ------------------------------------------------------------
    always_comb
    begin
        tf_len = 32'(led_regs_pkg::TF_MS[pump_q[4:2]] * TF_SCALE);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ps_q     <= PS_OFF;
            tf_cnt_q <= 32'h0000_0000;
            pump_on  <= 1'b0;
        end
        else
        begin
            unique case (ps_q)
                PS_OFF:
                    if (pump_q[led_regs_pkg::PUMP_EN_BIT])
                    begin
                        ps_q     <= PS_RUN;
                        tf_cnt_q <= 32'h0000_0000;
                    end
                PS_RUN:
                    if (!pump_q[led_regs_pkg::PUMP_EN_BIT])
                        ps_q <= PS_OFF;
                    else if (pump_q[led_regs_pkg::PUMP_RED_BIT])
                    begin
                        if (tf_cnt_q >= tf_len - 32'h1)
                        begin
                            ps_q     <= supply_ok ? PS_TRY : PS_RUN;
                            tf_cnt_q <= 32'h0000_0000;
                        end
                        else
                            tf_cnt_q <= tf_cnt_q + 32'h1;
                    end
                PS_TRY:
                    // Pump rests while supply holds up
                    if (!pump_q[led_regs_pkg::PUMP_EN_BIT])
                        ps_q <= PS_OFF;
                    else if (!supply_ok
                             || !pump_q[led_regs_pkg::PUMP_RED_BIT])
                        ps_q <= PS_RUN;
                default: ps_q <= PS_OFF;
            endcase
            pump_on <= (ps_q == PS_RUN);
        end
    end

    // ------------------------------------------------------------
    // Read data, registered
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (rd_en)
        begin
            unique case (addr)
                led_regs_pkg::CUR_A_ADDR:  rdata <= cur_a;
                led_regs_pkg::CUR_B_ADDR:  rdata <= cur_b;
                led_regs_pkg::CUR_C_ADDR:  rdata <= cur_c;
                led_regs_pkg::PUMP_ADDR:   rdata <= pump_q;
                led_regs_pkg::TEST_ADDR:   rdata <= test_q;
                led_regs_pkg::PDOWN_ADDR:  rdata <= pdown_q;
                led_regs_pkg::WDOG_ADDR:   rdata <= wdog_q;
                led_regs_pkg::FSTAT_ADDR:  rdata <= fstat_q;
                led_regs_pkg::GSTAT_ADDR:  rdata <= {2'b00, gstat_q, 4'h0};
                default:                   rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    pump_rst_a: assert property (@(posedge core_clk)
        $fell(rst_n) ##1 !rst_n |-> pump_q == 8'h1e)
        else $error("pump config reset value wrong");
    wdog_rst_a: assert property (@(posedge core_clk)
        $rose(rst_n) |-> wdog_q == 8'hff)
        else $error("watchdog config reset value wrong");
    test_go_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        test_start |=> fstat_q[6] || test_done)
        else $error("test start did not set busy");
    result_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        test_done |=> fstat_q[5:0] == $past(test_result)
                      && !fstat_q[6])
        else $error("test result not captured");
    shut_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !pdown_q[0] ##1 !pdown_q[0] |-> shutdown)
        else $error("left shutdown without enable");
    wd_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wd_fire |=> gstat_q[1] && bus_if_reset)
        else $error("watchdog expiry not flagged");
    quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_activity |=> !wd_fire)
        else $error("watchdog fired after activity");
    resv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pump_q[7:5] == 3'b000 && test_q[7:2] == 6'h00
        && pdown_q[7:1] == 7'h00 && fstat_q[7] == 1'b0)
        else $error("reserved bit set");
    full_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        test_q[1] |=> test_all_leds && test_no_light)
        else $error("full matrix not applied");
    pump_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !pump_q[0] ##1 !pump_q[0] ##1 !pump_q[0] |-> !pump_on)
        else $error("pump on while disabled");
endmodule

// ===== led_regs_pkg.sv
package led_regs_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CUR_A_ADDR   = 8'h05;
    localparam logic [7:0] CUR_B_ADDR   = 8'h06;
    localparam logic [7:0] CUR_C_ADDR   = 8'h07;
    localparam logic [7:0] PUMP_ADDR    = 8'h08;
    localparam logic [7:0] TEST_ADDR    = 8'h09;
    localparam logic [7:0] PDOWN_ADDR   = 8'h0a;
    localparam logic [7:0] WDOG_ADDR    = 8'h0b;
    localparam logic [7:0] FSTAT_ADDR   = 8'h0c;
    localparam logic [7:0] GSTAT_ADDR   = 8'h0d;
    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] CUR_RST      = 8'h00;
    localparam logic [7:0] PUMP_RST     = 8'h1e;
    localparam logic [7:0] PUMP_MASK    = 8'h1f;
    localparam logic [7:0] TEST_RST     = 8'h00;
    localparam logic [7:0] TEST_MASK    = 8'h03;
    localparam logic [7:0] PDOWN_RST    = 8'h00;
    localparam logic [7:0] PDOWN_MASK   = 8'h01;
    localparam logic [7:0] WDOG_RST     = 8'hff;
    localparam logic [7:0] WDOG_MASK    = 8'hff;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PUMP_EN_BIT   = 0;
    localparam int PUMP_RED_BIT  = 1;
    localparam int PUMP_TF_LO    = 2;
    localparam int TEST_RUN_BIT  = 0;
    localparam int TEST_FULL_BIT = 1;
    localparam int PDOWN_BIT     = 0;
    localparam int WDOG_EN_BIT   = 0;
    localparam int WDOG_TO_LO    = 1;  // Seven-bit window in bits 7:1
    localparam int FSTAT_BUSY    = 6;
    localparam int GSTAT_MON     = 5;
    localparam int GSTAT_POR     = 4;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 125;
    localparam int WDOG_UNIT_US  = 256;
    localparam int WDOG_UNIT_CYC = WDOG_UNIT_US * CLK_MHZ;
    localparam int TF_MS [8]     = '{300, 500, 800, 1000,
                                     1300, 1600, 1800, 2100};
    localparam int LED_COUNT     = 144;
endpackage

// ===== scan_engine_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Stand-in for the LED fault scan engine
// ------------------------------------------------------------
module scan_engine_model #(
    parameter int SCAN_CYC = 20  // Scan length in cycles
) (
    input  wire logic       core_clk,
    input  wire logic       test_start,
    input  wire logic [5:0] scan_result,
    output logic            test_done,
    output logic [5:0]      test_result
);
    int         left = 0;      // Cycles of scan still to run
    logic [5:0] last = 6'h00;  // Last result handed over
    initial test_done = 1'b0;
    initial test_result = 6'h00;
    // Done only after a start; result valid with done only
    always @(posedge core_clk)
    begin
        test_done <= 1'b0;
        test_result <= ~last;  // Stale result not held
        if (left == 1)
        begin
            test_done <= 1'b1;
            test_result <= scan_result;
            last <= scan_result;
        end
        left <= test_start ? SCAN_CYC : (left > 0 ? left - 1 : 0);
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ns
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       core_clk, rst_n, wr_en, rd_en, bus_activity, bus_stuck;
    logic       supply_ok, test_done, pump_on, test_start, shutdown;
    logic       test_all_leds, test_no_light, bus_if_reset;
    logic [7:0] addr, wdata, rdata, cur_a, cur_b, cur_c;
    logic [5:0] test_result;
    int         fails = 0;     // Mismatches
    int         check_count = 0;
    int         starts = 0;    // Scan start pulses seen
    int         fires = 0;     // Interface resets seen
    int         n;             // Cycle counter for waits
    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    led_ctrl_regs #(.WDOG_UNIT(4), .TF_SCALE(10)) u_led_ctrl_regs (
        .core_clk(core_clk), .rst_n(rst_n), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .bus_activity(bus_activity), .bus_stuck(bus_stuck),
        .test_done(test_done), .test_result(test_result),
        .supply_ok(supply_ok), .rdata(rdata), .cur_a(cur_a),
        .cur_b(cur_b), .cur_c(cur_c), .pump_on(pump_on),
        .test_start(test_start), .test_all_leds(test_all_leds),
        .test_no_light(test_no_light), .shutdown(shutdown),
        .bus_if_reset(bus_if_reset));
    scan_engine_model u_scan_engine_model (
        .core_clk(core_clk), .test_start(test_start),
        .scan_result(6'h2b), .test_done(test_done),
        .test_result(test_result));
    // Clock and event counters
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (test_start === 1'b1) starts++;
        if (bus_if_reset === 1'b1) fires++;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge core_clk);
        wr_en = 1'b0;
    endtask
    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
        @(negedge core_clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge core_clk);
        rd_en = 1'b0;
        @(negedge core_clk);
        chk(what, exp, rdata);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("shutdown", 8'h01, {7'h00, shutdown});
        rchk("pump cfg", led_regs_pkg::PUMP_ADDR, 8'h1e);
        rchk("wdog cfg", led_regs_pkg::WDOG_ADDR, 8'hff);
        rchk("pdown", led_regs_pkg::PDOWN_ADDR, 8'h00);
        rchk("cur c", led_regs_pkg::CUR_C_ADDR, 8'h00);
        rchk("fstat", led_regs_pkg::FSTAT_ADDR, 8'h00);
        rchk("gstat por", led_regs_pkg::GSTAT_ADDR, 8'h10);
        rchk("gstat clr", led_regs_pkg::GSTAT_ADDR, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(led_regs_pkg::CUR_A_ADDR, 8'hff);
        wr(led_regs_pkg::CUR_B_ADDR, 8'h80);
        wr(led_regs_pkg::CUR_C_ADDR, 8'h01);
        chk("cur_a", 8'hff, cur_a);
        chk("cur_b", 8'h80, cur_b);
        chk("cur_c", 8'h01, cur_c);
        rchk("cur b", led_regs_pkg::CUR_B_ADDR, 8'h80);
        wr(8'h20, 8'hff);
        rchk("unmapped", 8'h20, 8'h00);
        wr(led_regs_pkg::PDOWN_ADDR, 8'hff);
        rchk("pdown", led_regs_pkg::PDOWN_ADDR, 8'h01);
        @(negedge core_clk);
        chk("run", 8'h00, {7'h00, shutdown});
        wr(led_regs_pkg::TEST_ADDR, 8'hfd);
        rchk("test rsv", led_regs_pkg::TEST_ADDR, 8'h01);
        $display("test regs done");
    endtask
    task automatic t_scan();
        n = starts;
        wr(led_regs_pkg::TEST_ADDR, 8'h00);
        wr(led_regs_pkg::TEST_ADDR, 8'h00);
        rchk("busy", led_regs_pkg::FSTAT_ADDR, 8'h40);
        chk("one start", 8'h01, 8'(starts - n));
        repeat (25) @(negedge core_clk);
        rchk("result", led_regs_pkg::FSTAT_ADDR, 8'h2b);
        wr(led_regs_pkg::TEST_ADDR, 8'h03);
        @(negedge core_clk);
        chk("all leds", 8'h01, {7'h00, test_all_leds});
        chk("no light", 8'h01, {7'h00, test_no_light});
        chk("no start", 8'h01, 8'(starts - n));
        wr(led_regs_pkg::TEST_ADDR, 8'h01);
        @(negedge core_clk);
        chk("frame leds", 8'h00, {7'h00, test_all_leds});
        $display("test scan done");
    endtask
    task automatic t_wdog();
        for (int f = 0; f < 4; f += 3)
        begin
            wr(led_regs_pkg::WDOG_ADDR, 8'((f << 1) | 1));
            bus_stuck = 1'b1;
            n = 0;
            while (bus_if_reset !== 1'b1 && n < 60)
            begin
                @(negedge core_clk);
                n++;
            end
            bus_stuck = 1'b0;
            // Window of (f+1) units of 4 cycles, plus output latency
            chk("window", 8'h01,
                8'(n >= (f + 1) * 4 && n <= (f + 1) * 4 + 3));
        end
        rchk("gstat mon", led_regs_pkg::GSTAT_ADDR, 8'h20);
        n = fires;
        bus_stuck = 1'b1;
        bus_activity = 1'b1;
        repeat (40) @(negedge core_clk);
        chk("restart", 8'h00, 8'(fires - n));
        bus_activity = 1'b0;
        wr(led_regs_pkg::WDOG_ADDR, 8'h00);
        repeat (40) @(negedge core_clk);
        chk("mon off", 8'h00, 8'(fires - n));
        bus_stuck = 1'b0;
        $display("test watchdog done");
    endtask
    task automatic t_pump();
        supply_ok = 1'b1;
        wr(led_regs_pkg::PUMP_ADDR, 8'h03);
        repeat (2800) @(negedge core_clk);
        chk("pump runs", 8'h01, {7'h00, pump_on});
        repeat (300) @(negedge core_clk);
        chk("pump rests", 8'h00, {7'h00, pump_on});
        supply_ok = 1'b0;
        repeat (5) @(negedge core_clk);
        chk("pump back", 8'h01, {7'h00, pump_on});
        wr(led_regs_pkg::PUMP_ADDR, 8'h00);
        // State leaves run one edge after the write, output one later
        repeat (2) @(negedge core_clk);
        chk("pump off", 8'h00, {7'h00, pump_on});
        $display("test pump done");
    endtask
    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        {wr_en, rd_en, bus_activity, bus_stuck, supply_ok} = 5'h00;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_scan();
        t_wdog();
        t_pump();
        give_verdict();
    end
    initial
    begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule
